// File: verilog/afc_pkg.sv
package afc_pkg;
  // ************************************************************
  // Widths
  // ************************************************************
  localparam int AFC_DW = 9;
  localparam int AFC_AW = 4;
  localparam int AFC_CW = 8;

  // ************************************************************
  // Register map of the controller
  // ************************************************************
  localparam logic [AFC_AW-1:0] AFC_REG_CTRL = 4'h0;
  localparam logic [AFC_AW-1:0] AFC_REG_WDATA = 4'h1;
  localparam logic [AFC_AW-1:0] AFC_REG_RDATA = 4'h2;
  localparam logic [AFC_AW-1:0] AFC_REG_STAT = 4'h3;
  // CTRL bits
  localparam int AFC_CTRL_RESET = 0;
  localparam int AFC_CTRL_REPLAY = 1;
  localparam int AFC_CTRL_CHAIN = 2;
  localparam int AFC_CTRL_FIRST = 3;
  // Command codes, written into WDATA bit positions above the data
  localparam int AFC_WCMD_BIT = 31;
  localparam int AFC_RCMD_BIT = 30;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int AFC_CLK_NS = 20;
  localparam int AFC_PULSE_NS = 40;
  localparam int AFC_RST_NS = 100;
  localparam int AFC_PULSE_CYC = (AFC_PULSE_NS + AFC_CLK_NS - 1) / AFC_CLK_NS;
  localparam int AFC_RST_CYC = (AFC_RST_NS + AFC_CLK_NS - 1) / AFC_CLK_NS;
  localparam logic [AFC_CW-1:0] AFC_PULSE_CNT = AFC_CW'(AFC_PULSE_CYC);
  localparam logic [AFC_CW-1:0] AFC_RST_CNT = AFC_CW'(AFC_RST_CYC);
  localparam logic [AFC_CW-1:0] AFC_CNT_ZERO = 8'h00;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [4:0] {
    AFC_IDLE = 5'b0_0001,
    AFC_WR = 5'b0_0010,
    AFC_RD = 5'b0_0100,
    AFC_CLR = 5'b0_1000,
    AFC_RPL = 5'b1_0000
  } afc_state_t;

  typedef struct packed {
    logic write_n;
    logic read_n;
    logic clear_n;
    logic replay_n;
    logic chain_in_n;
    logic [AFC_DW-1:0] data;
  } afc_pins_out_t;

  typedef struct packed {
    logic empty_flag_n;
    logic full_indicator_n;
    logic half_full_indicator_n;
  } afc_flags_t;

  typedef struct packed {
    afc_state_t st;
    logic [AFC_CW-1:0] cnt;
    logic [AFC_DW-1:0] wdata;
    logic [AFC_DW-1:0] rdata;
    logic [AFC_DW-1:0] rdata_bus;
    logic [3:0] ctrl;
    logic wr_pend;
    logic rd_pend;
    logic ovf;
    logic unf;
    logic rd_valid;
    afc_flags_t fl_s1;
    afc_flags_t fl_s2;
    logic [AFC_DW-1:0] q_s1;
    logic [AFC_DW-1:0] q_s2;
    afc_pins_out_t pins;
  } afc_state_s_t;
endpackage

// File: verilog/afc_ctrl.sv
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/100ps
// Functional notes
// - Writer watches full, reader watches empty.
// - Exactly one chained FIFO first-load low.
// - Other chained FIFOs hold first-load high.
// - Chain-out feeds next device chain-in.
// - Composite flags OR all devices' flags.
// - Strobes held high around reset release.
// - Writer strobes only while full deasserted.
module afc_ctrl
  import afc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Register port
  input wire logic [AFC_AW-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata,
  // FIFO pins
  output logic write_n,
  output logic read_n,
  output logic clear_input_n,
  output logic replay_input_n,
  output logic first_load_select_n,
  output logic chain_in_n,
  output logic [AFC_DW-1:0] fifo_d,
  input wire logic [AFC_DW-1:0] fifo_q,
  input wire logic empty_flag_n,
  input wire logic full_indicator_n,
  input wire logic half_full_indicator_n
);

  // ************************************************************
  // State
  // ************************************************************
  afc_state_s_t s_r;
  afc_state_s_t s_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic ready;
  logic busy;

  assign busy = (s_r.st != AFC_IDLE);
  // Flags trusted only after clear interval ends
  assign ready = !busy && s_r.ctrl[AFC_CTRL_RESET] == 1'b0;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    s_nxt = s_r;
    rdata_nxt = 32'h0000_0000;
    // Flag pins may carry the OR of every chained device's flags
    s_nxt.fl_s1 = '{empty_flag_n, full_indicator_n, half_full_indicator_n};
    s_nxt.fl_s2 = s_r.fl_s1;
    s_nxt.q_s1 = fifo_q;
    s_nxt.q_s2 = s_r.q_s1;
    if (wr_stb) begin
      unique case (addr)
        AFC_REG_CTRL: begin
          s_nxt.ctrl = wdata[3:0];
        end
        AFC_REG_WDATA: begin
          if (wdata[AFC_WCMD_BIT]) begin
            s_nxt.wdata = wdata[AFC_DW-1:0];
            s_nxt.wr_pend = 1'b1;
          end
          if (wdata[AFC_RCMD_BIT]) begin
            s_nxt.rd_pend = 1'b1;
          end
        end
        AFC_REG_STAT: begin
          // Write one clears sticky errors
          s_nxt.ovf = s_r.ovf & ~wdata[4];
          s_nxt.unf = s_r.unf & ~wdata[5];
        end
        default: begin
        end
      endcase
    end
    if (rd_stb) begin
      unique case (addr)
        AFC_REG_CTRL: rdata_nxt = {28'h000_0000, s_r.ctrl};
        AFC_REG_RDATA: begin
          rdata_nxt = {22'h00_0000, s_r.rd_valid, s_r.rdata};
          s_nxt.rd_valid = 1'b0;
        end
        AFC_REG_STAT: rdata_nxt = {26'h000_0000, busy, s_r.unf, s_r.ovf,
                                   s_r.fl_s2.half_full_indicator_n,
                                   s_r.fl_s2.full_indicator_n,
                                   s_r.fl_s2.empty_flag_n};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
    if (s_r.cnt != AFC_CNT_ZERO) begin
      s_nxt.cnt = s_r.cnt - 8'h01;
    end
    unique case (s_r.st)
      AFC_IDLE: begin
        s_nxt.pins.write_n = 1'b1;
        s_nxt.pins.read_n = 1'b1;
        if (s_r.ctrl[AFC_CTRL_RESET]) begin
          // Both strobes already high before clear is driven
          s_nxt.pins.clear_n = 1'b0;
          s_nxt.cnt = AFC_RST_CNT;
          s_nxt.st = AFC_CLR;
        end else if (s_r.ctrl[AFC_CTRL_REPLAY]) begin
          if (!s_r.ctrl[AFC_CTRL_CHAIN]) begin
            // Replay only in single mode; strobes high throughout
            s_nxt.pins.replay_n = 1'b0;
            s_nxt.cnt = AFC_PULSE_CNT;
            s_nxt.st = AFC_RPL;
          end else begin
            // Refused when chained; dropped so a later mode change cannot fire it
            s_nxt.ctrl[AFC_CTRL_REPLAY] = 1'b0;
          end
        end else if (s_r.wr_pend && ready) begin
          s_nxt.wr_pend = 1'b0;
          if (s_r.fl_s2.full_indicator_n) begin
            // Strobe only while not full
            s_nxt.pins.data = s_r.wdata;
            s_nxt.pins.write_n = 1'b0;
            s_nxt.cnt = AFC_PULSE_CNT;
            s_nxt.st = AFC_WR;
          end else begin
            s_nxt.ovf = 1'b1;
          end
        end else if (s_r.rd_pend && ready) begin
          s_nxt.rd_pend = 1'b0;
          if (s_r.fl_s2.empty_flag_n) begin
            s_nxt.pins.read_n = 1'b0;
            s_nxt.cnt = AFC_PULSE_CNT;
            s_nxt.st = AFC_RD;
          end else begin
            s_nxt.unf = 1'b1;
          end
        end
      end
      AFC_WR: begin
        if (s_r.cnt == AFC_CNT_ZERO) begin
          // Rising write edge stores the word
          s_nxt.pins.write_n = 1'b1;
          s_nxt.st = AFC_IDLE;
        end
      end
      AFC_RD: begin
        if (s_r.cnt == AFC_CNT_ZERO) begin
          // Sample before the rising edge; outputs float after it
          s_nxt.rdata = s_r.q_s2;
          s_nxt.rd_valid = 1'b1;
          s_nxt.pins.read_n = 1'b1;
          s_nxt.st = AFC_IDLE;
        end
      end
      AFC_CLR: begin
        if (s_r.cnt == AFC_CNT_ZERO) begin
          s_nxt.pins.clear_n = 1'b1;
          s_nxt.ctrl[AFC_CTRL_RESET] = 1'b0;
          s_nxt.cnt = AFC_RST_CNT;
          s_nxt.st = AFC_RPL;
        end
      end
      AFC_RPL: begin
        // Also used as the recovery wait after clear
        if (s_r.cnt == AFC_CNT_ZERO) begin
          s_nxt.pins.replay_n = 1'b1;
          s_nxt.ctrl[AFC_CTRL_REPLAY] = 1'b0;
          s_nxt.st = AFC_IDLE;
        end
      end
    endcase
    // Chain-in low selects single mode, high selects chain mode with first-load from control
    // Stands in for the previous device's chain-out
    s_nxt.pins.chain_in_n = s_r.ctrl[AFC_CTRL_CHAIN];
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s_r <= '{st: AFC_IDLE, cnt: AFC_CNT_ZERO,
               pins: '{write_n: 1'b1, read_n: 1'b1, clear_n: 1'b1,
                       replay_n: 1'b1, chain_in_n: 1'b0, data: '0},
               default: '0};
      rdata_r <= 32'h0000_0000;
    end else begin
      s_r <= s_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign rdata = rdata_r;
  assign write_n = s_r.pins.write_n;
  assign read_n = s_r.pins.read_n;
  assign clear_input_n = s_r.pins.clear_n;
  assign replay_input_n = s_r.pins.replay_n;
  // Shared pin: first-load in chain mode, replay otherwise
  // Follows the chain-in pin, so it never turns low ahead of a change into chain mode
  assign first_load_select_n = s_r.pins.chain_in_n ?
                               s_r.ctrl[AFC_CTRL_FIRST] : s_r.pins.replay_n;
  assign chain_in_n = s_r.pins.chain_in_n;
  assign fifo_d = s_r.pins.data;

endmodule

// File: verif/afc_chk_props.sv
`timescale 1ns/100ps
module afc_chk
  import afc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // FIFO pins
  input wire logic write_n,
  input wire logic read_n,
  input wire logic clear_input_n,
  input wire logic replay_input_n,
  input wire logic chain_in_n,
  input wire logic empty_flag_n,
  input wire logic full_indicator_n
);
  // ****
  // Checks
  // ****
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  sequence clr_pulse;
    !clear_input_n [*6] ##1 clear_input_n;
  endsequence
  sequence wr_pulse;
    !write_n [*3] ##1 write_n;
  endsequence
  rst_idle_a: assert property ($rose(rst_b) |-> write_n && read_n)
    else $error("strobe active at reset release");
  rst_single_a: assert property ($rose(rst_b) |-> !chain_in_n && clear_input_n)
    else $error("mode or clear wrong at reset release");
  clr_quiet_a: assert property (!clear_input_n |-> write_n && read_n)
    else $error("strobe active during clear");
  clr_width_a: assert property ($fell(clear_input_n) |-> clr_pulse)
    else $error("clear pulse width wrong");
  // Flags arrive late through synchronisers, so allow a margin
  wr_full_a: assert property (!full_indicator_n [*5] |-> !$fell(write_n))
    else $error("write started while full");
  rd_empty_a: assert property (!empty_flag_n [*5] |-> !$fell(read_n))
    else $error("read started while empty");
  wr_width_a: assert property ($fell(write_n) |-> wr_pulse)
    else $error("write pulse width wrong");
  rpl_quiet_a: assert property (!replay_input_n |-> write_n && read_n)
    else $error("strobe active during replay");
endmodule
bind afc_ctrl afc_chk u_chk (.mclk(mclk), .rst_b(rst_b), .write_n(write_n), .read_n(read_n),
  .clear_input_n(clear_input_n), .replay_input_n(replay_input_n), .chain_in_n(chain_in_n),
  .empty_flag_n(empty_flag_n), .full_indicator_n(full_indicator_n));

// File: verif/afc_fifo_model.sv
`timescale 1ns/100ps
module afc_fifo_model
  import afc_pkg::*;
#(
  parameter int DEPTH = 4
) (
  // Strobes and mode
  input wire logic write_n,
  input wire logic read_n,
  input wire logic clear_input_n,
  input wire logic first_load_select_n,
  input wire logic chain_in_n,
  // Data and flags
  input wire logic [AFC_DW-1:0] fifo_d,
  output logic [AFC_DW-1:0] fifo_q,
  output logic empty_flag_n,
  output logic full_indicator_n,
  output logic half_full_indicator_n
);
  // ****
  // Array and pointers
  // ****
  // One channel per instance; a second channel is a second instance
  logic [AFC_DW-1:0] mem [DEPTH];
  logic [AFC_DW-1:0] last = '0;
  int wp = 0;
  int rp = 0;
  always @(negedge clear_input_n) begin
    wp = 0;
    rp = 0;
  end
  // A write held low over a read is taken at its rising edge
  always @(posedge write_n) if (clear_input_n && wp - rp < DEPTH) begin
    mem[wp % DEPTH] = fifo_d;
    wp++;
  end
  always @(posedge read_n) if (clear_input_n && wp != rp) begin
    last = mem[rp % DEPTH];
    rp++;
  end
  // Replay only in single mode
  always @(negedge first_load_select_n) if (!chain_in_n) rp = 0;
  assign empty_flag_n = clear_input_n && wp != rp;
  assign full_indicator_n = !clear_input_n || wp - rp != DEPTH;
  assign half_full_indicator_n = chain_in_n || wp - rp <= DEPTH / 2;
  // Floating bus shows inverse of last word, not a stale copy
  assign fifo_q = (!read_n && wp != rp) ? mem[rp % DEPTH] : ~last;
endmodule

// File: verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import afc_pkg::*;
  logic mclk;
  logic rst_b = 1'b0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [AFC_AW-1:0] addr = '0;
  logic [31:0] wdata = '0;
  logic [31:0] rdata;
  logic [31:0] rv;
  logic w_n, r_n, clr_n, fl_n, chn_n, ef_n, ff_n, hf_n;
  logic [AFC_DW-1:0] d, q;
  logic [AFC_DW-1:0] pat [3] = '{9'h1a5, 9'h05a, 9'h100};
  int failures = 0;
  int checks = 0;
  afc_ctrl DUT (.mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .write_n(w_n), .read_n(r_n), .clear_input_n(clr_n),
    .replay_input_n(), .first_load_select_n(fl_n), .chain_in_n(chn_n), .fifo_d(d),
    .fifo_q(q), .empty_flag_n(ef_n), .full_indicator_n(ff_n), .half_full_indicator_n(hf_n));
  afc_fifo_model #(.DEPTH(4)) u_fifo (.write_n(w_n), .read_n(r_n), .clear_input_n(clr_n),
    .first_load_select_n(fl_n), .chain_in_n(chn_n), .fifo_d(d), .fifo_q(q),
    .empty_flag_n(ef_n), .full_indicator_n(ff_n), .half_full_indicator_n(hf_n));
  // ****
  // Bus tasks
  // ****
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [AFC_AW-1:0] a, input logic [31:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [AFC_AW-1:0] a, output logic [31:0] v);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1;
    v = rdata;
  endtask
  // Extra wait lets synchronised flags settle before the next command
  task automatic op(input logic [AFC_AW-1:0] a, input logic [31:0] v);
    logic [31:0] s;
    wr(a, v);
    repeat (3) @(posedge mclk);
    s = 32'h0000_0020;
    for (int i = 0; i < 30 && s[5] !== 1'b0; i++) rd(AFC_REG_STAT, s);
    cmp("busy", 32'h0000_0000, s & 32'h0000_0020);
    repeat (4) @(posedge mclk);
  endtask
  task automatic stat(input logic [31:0] e);
    rd(AFC_REG_STAT, rv);
    cmp("status", e, rv);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    op(AFC_REG_CTRL, 32'h0000_0001);
    stat(32'h0000_0006);
    rd(AFC_REG_CTRL, rv);
    cmp("control", 32'h0000_0000, rv);
    $display("test reset done");
  endtask
  task automatic t_rw;
    foreach (pat[i]) op(AFC_REG_WDATA, 32'h8000_0000 | 32'(pat[i]));
    op(AFC_REG_WDATA, 32'h4000_0000);
    rd(AFC_REG_RDATA, rv);
    cmp("first word", 32'h0000_0200 | 32'(pat[0]), rv);
    op(AFC_REG_CTRL, 32'h0000_0002);
    foreach (pat[i]) begin
      op(AFC_REG_WDATA, 32'h4000_0000);
      rd(AFC_REG_RDATA, rv);
      cmp("replayed word", 32'h0000_0200 | 32'(pat[i]), rv);
    end
    stat(32'h0000_0006);
    $display("test write read replay done");
  endtask
  task automatic t_unf;
    op(AFC_REG_WDATA, 32'h4000_0000);
    stat(32'h0000_0016);
    op(AFC_REG_STAT, 32'h0000_0020);
    stat(32'h0000_0006);
    $display("test underflow done");
  endtask
  task automatic t_full;
    for (int i = 0; i < 5; i++) op(AFC_REG_WDATA, 32'h8000_0000 | i);
    stat(32'h0000_0009);
    op(AFC_REG_STAT, 32'h0000_0010);
    stat(32'h0000_0001);
    $display("test full done");
  endtask
  // Chain on with first-load high first, so the shared pin never falls in single mode
  task automatic t_chain;
    op(AFC_REG_CTRL, 32'h0000_000c);
    cmp("chain in", 32'h0000_0001, chn_n);
    cmp("first load", 32'h0000_0001, fl_n);
    op(AFC_REG_CTRL, 32'h0000_0004);
    cmp("first load", 32'h0000_0000, fl_n);
    op(AFC_REG_CTRL, 32'h0000_0006);
    rd(AFC_REG_CTRL, rv);
    cmp("control", 32'h0000_0004, rv);
    stat(32'h0000_0005);
    op(AFC_REG_WDATA, 32'h4000_0000);
    rd(AFC_REG_RDATA, rv);
    cmp("chained word", 32'h0000_0200, rv);
    op(AFC_REG_CTRL, 32'h0000_0000);
    cmp("chain in", 32'h0000_0000, chn_n);
    $display("test chain mode done");
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Tests need a few hundred cycles; allow ample margin
  initial begin
    #400_000;
    failures++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset();
    t_rw();
    t_unf();
    t_full();
    t_chain();
    stop_test();
  end
endmodule
